// ===== src/pdt_pkg.sv
package pdt_pkg;

	// ***********************************************************
	// Framing constants
	// ***********************************************************
	localparam int         TS_PKT_LEN   = 188;
	localparam logic [7:0] TS_LAST      = 8'(TS_PKT_LEN - 1);
	localparam logic [7:0] TS_SYNC      = 8'h47;
	localparam int         PID_W        = 13;
	localparam int         NSTR         = 4;
	localparam int         STR_W        = 2;
	localparam int         NTB          = 2;
	localparam int         TB_W         = 1;
	localparam int         BASE_W       = 33;
	localparam int         EXT_W        = 9;
	localparam logic [23:0] START_PFX   = 24'h000001;
	localparam logic [15:0] ZERO_PAIR   = 16'h0000;
	localparam logic [7:0] SC_LAST      = 8'h01;
	localparam logic [7:0] SID_PACK     = 8'hba;
	localparam logic [7:0] SID_MIN      = 8'hbc;
	localparam logic [7:0] SID_PAD      = 8'hbe;
	localparam logic [7:0] SID_PRIV2    = 8'hbf;
	localparam logic [3:0] PES_HLEN_IDX = 4'h8;
	localparam logic [3:0] PES_BODY     = 4'h9;
	localparam logic [3:0] PCR_LAST_IDX = 4'h6;
	localparam logic [3:0] AF_IDX_MAX   = 4'hf;
	localparam int         AF_PCR_BIT   = 4;
	localparam int         PUSI_BIT     = 6;
	localparam int         AFC_LSB      = 4;

	// ***********************************************************
	// Time base constants
	// ***********************************************************
	localparam int         CLK_HZ       = 50_000_000;
	localparam int         STC_HZ       = 27_000_000;
	localparam int         RATE_GCD     = 1_000_000;
	localparam logic [6:0] STC_INC      = 7'(STC_HZ / RATE_GCD);
	localparam logic [6:0] STC_MOD      = 7'(CLK_HZ / RATE_GCD);
	localparam logic [8:0] EXT_MOD      = 9'h12c;
	localparam logic [8:0] EXT_LAST     = EXT_MOD - 9'h001;

	typedef enum logic [3:0] {
		S_HUNT    = 4'h0,
		S_TSH1    = 4'h1,
		S_TSH2    = 4'h2,
		S_TSH3    = 4'h3,
		S_AFLEN   = 4'h4,
		S_AF      = 4'h5,
		S_TSPAY   = 4'h6,
		S_TSSKIP  = 4'h7,
		S_PSSCAN  = 4'h8,
		S_PSSID   = 4'h9,
		S_PSLEN1  = 4'ha,
		S_PSLEN2  = 4'hb,
		S_PSFLG   = 4'hc,
		S_PSHLEN  = 4'hd,
		S_PSHSKIP = 4'he,
		S_PSPAY   = 4'hf
	} pdt_state_t;

endpackage

// ===== src/pdt_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module pdt_timebase
(
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic                        ce,
	input  wire logic                        load,
	input  wire logic [pdt_pkg::BASE_W-1:0]  load_base,
	input  wire logic [pdt_pkg::EXT_W-1:0]   load_ext,
	output logic      [pdt_pkg::BASE_W-1:0]  stc_base,
	output logic      [pdt_pkg::EXT_W-1:0]   stc_ext,
	output logic      [pdt_pkg::BASE_W-1:0]  err
);

	logic [6:0]                 acc;
	logic [6:0]                 next_acc;
	logic [6:0]                 sum;
	logic                       tick;
	logic [pdt_pkg::BASE_W-1:0] next_base;
	logic [pdt_pkg::EXT_W-1:0]  next_ext;
	logic [pdt_pkg::BASE_W-1:0] next_err;

	// The 27 MHz count is made from the 50 MHz clock by a fractional
	// accumulator, so ticks jitter by one clock but never drift.
	always_comb
	begin
		sum = acc + pdt_pkg::STC_INC;
		tick = (sum >= pdt_pkg::STC_MOD);
		next_acc = tick ? sum - pdt_pkg::STC_MOD : sum;
		next_base = stc_base;
		next_ext = stc_ext;
		next_err = err;
		if (load)
		begin
			// The phase error at each reference lets the owner steer
			// its clock and buffers around late or early arrival.
			next_err = load_base - stc_base;  // see R12
			next_base = load_base;
			next_ext = load_ext;
			next_acc = 7'h00;
		end
		else if (tick)
		begin
			if (stc_ext == pdt_pkg::EXT_LAST)  // see R15
			begin
				next_ext = 9'h000;
				next_base = stc_base + 33'h000000001;  // see R6
			end
			else
				next_ext = stc_ext + 9'h001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			acc <= 7'h00;
			stc_base <= '0;
			stc_ext <= '0;
			err <= '0;
		end
		else if (ce)
		begin
			acc <= next_acc;
			stc_base <= next_base;
			stc_ext <= next_ext;
			err <= next_err;
		end
	end

	ext_range_a: assert property (@(posedge clk) disable iff (srst) // see R6
		stc_ext < pdt_pkg::EXT_MOD)
		else $error("Extension count left its range.");

	ext_wrap_a: assert property (@(posedge clk) disable iff (srst) // see R15
		(ce && tick && !load && stc_ext == pdt_pkg::EXT_LAST)
		|=> (stc_ext == 9'h000 && stc_base == $past(stc_base) + 33'h1))
		else $error("Base did not advance on extension wrap.");

	tb_load_a: assert property (@(posedge clk) disable iff (srst) // see R12
		(ce && load) |=> (stc_base == $past(load_base)
		&& err == $past(load_base) - $past(stc_base)))
		else $error("Reference load or phase error wrong.");

endmodule
`default_nettype wire

// ===== src/pdt_demux.sv
// Overview of operation
// R1: Transport input is framed on fixed 188-byte packets behind a sync byte.
// R2: All payload of one elementary packet goes to a single stream output.
// R3: Streams are selected by stream id in program mode and by PID in transport mode.
// R4: A standalone elementary packet source carries clock reference and rate fields.
// R5: Payload bytes leave in their original order with no gaps or reordering.
// R6: Time stamps count at 90 kHz and clock references carry a 27 MHz extension.
// R7: Each program has exactly one clock reference time base, independent of others.
// R8: Clock references are tracked per time base, and programs may share one.
// R9: Start codes split across a packet header are rejoined on each stream.
// R10: Payload bytes are kept byte aligned to the multiplexed stream.
// R11: The source keeps its system clock locked to its sample clocks.
// R12: Arrival deviation is compensated by reporting phase error at each reference.
// R13: Every stream is slaved to its program's common master time base.
// R14: Elementary packets of any length, spanning many transport packets, are taken.
// R15: Each time base is a 27 MHz counter with a 90 kHz base at division by 300.
`timescale 1ns/1ps
`default_nettype none
module pdt_demux
(
	input  wire logic                                       clk,
	input  wire logic                                       srst,
	input  wire logic                                       ce,
	input  wire logic                                       ps_mode,
	input  wire logic [7:0]                                 in_data,
	input  wire logic                                       in_valid,
	input  wire logic [pdt_pkg::NSTR-1:0]                   str_en,
	input  wire logic [pdt_pkg::NSTR*pdt_pkg::PID_W-1:0]    str_pid,
	input  wire logic [pdt_pkg::NSTR*8-1:0]                 str_sid,
	input  wire logic [pdt_pkg::NSTR*pdt_pkg::TB_W-1:0]     str_tb,
	input  wire logic [pdt_pkg::NTB*pdt_pkg::PID_W-1:0]     pcr_pid,
	output logic      [7:0]                                 out_data,
	output logic                                            out_valid,
	output logic      [pdt_pkg::STR_W-1:0]                  out_stream,
	output logic                                            out_start,
	output logic      [pdt_pkg::BASE_W-1:0]                 out_stc_base,
	output logic                                            sync_lock,
	output logic      [pdt_pkg::NTB*pdt_pkg::BASE_W-1:0]    stc_base,
	output logic      [pdt_pkg::NTB*pdt_pkg::EXT_W-1:0]     stc_ext,
	output logic      [pdt_pkg::NTB*pdt_pkg::BASE_W-1:0]    tb_err
);

	// ***********************************************************
	// State
	// ***********************************************************
	pdt_pkg::pdt_state_t        st, next_st;
	logic [7:0]                 pkt_cnt, next_pkt_cnt;
	logic [pdt_pkg::PID_W-1:0]  pid, next_pid;
	logic                       pusi, next_pusi;
	logic                       pay_on, next_pay_on;
	logic [15:0]                cnt, next_cnt;
	logic [7:0]                 hskip, next_hskip;
	logic [3:0]                 pes_idx, next_pes_idx;
	logic [3:0]                 af_idx, next_af_idx;
	logic                       pcr_flag, next_pcr_flag;
	logic [47:0]                pcr_sr, next_pcr_sr;
	logic                       pcr_ld, next_pcr_ld;
	logic [pdt_pkg::STR_W-1:0]  cur_str, next_cur_str;
	logic                       cur_hit, next_cur_hit;
	logic [15:0]                zhist, next_zhist;
	logic [15:0]                hist [pdt_pkg::NSTR];
	logic [15:0]                next_hist [pdt_pkg::NSTR];
	logic [7:0]                 next_out_data;
	logic                       next_out_valid;
	logic [pdt_pkg::STR_W-1:0]  next_out_stream;
	logic                       next_out_start;
	logic [pdt_pkg::BASE_W-1:0] next_out_stc;
	logic                       next_lock;
	logic                       emit;
	logic                       pid_hit, sid_hit;
	logic [pdt_pkg::STR_W-1:0]  pid_str, sid_str;
	logic [pdt_pkg::TB_W-1:0]   cur_tb;

	// ***********************************************************
	// Stream selection
	// ***********************************************************
	// Lowest index wins so that one packet never feeds two outputs.
	always_comb
	begin
		pid_hit = 1'b0;
		sid_hit = 1'b0;
		pid_str = '0;
		sid_str = '0;
		for (int i = pdt_pkg::NSTR - 1; i >= 0; i--)
		begin
			if (str_en[i] && str_pid[i*pdt_pkg::PID_W +: pdt_pkg::PID_W]
				== {pid[12:8], in_data})  // see R3
			begin
				pid_hit = 1'b1;
				pid_str = pdt_pkg::STR_W'(i);
			end
			if (str_en[i] && str_sid[i*8 +: 8] == in_data)  // see R3
			begin
				sid_hit = 1'b1;
				sid_str = pdt_pkg::STR_W'(i);
			end
		end
	end

	assign cur_tb = str_tb[cur_str*pdt_pkg::TB_W +: pdt_pkg::TB_W];

	// ***********************************************************
	// Time bases
	// ***********************************************************
	// One counter per program clock reference; streams of programs that
	// share a reference are mapped onto the same counter.
	for (genvar k = 0; k < pdt_pkg::NTB; k++)
	begin : g_tb
		pdt_timebase u_tb
		(
			.clk       (clk),
			.srst      (srst),
			.ce        (ce),
			.load      (pcr_ld && pid == pcr_pid[k*pdt_pkg::PID_W +:
			            pdt_pkg::PID_W]),  // see R7, R8
			.load_base (pcr_sr[47:15]),
			.load_ext  (pcr_sr[8:0]),
			.stc_base  (stc_base[k*pdt_pkg::BASE_W +: pdt_pkg::BASE_W]),
			.stc_ext   (stc_ext[k*pdt_pkg::EXT_W +: pdt_pkg::EXT_W]),
			.err       (tb_err[k*pdt_pkg::BASE_W +: pdt_pkg::BASE_W])
		);
	end

	// ***********************************************************
	// Parser
	// ***********************************************************
	always_comb
	begin
		next_st = st;
		next_pkt_cnt = pkt_cnt;
		next_pid = pid;
		next_pusi = pusi;
		next_pay_on = pay_on;
		next_cnt = cnt;
		next_hskip = hskip;
		next_pes_idx = pes_idx;
		next_af_idx = af_idx;
		next_pcr_flag = pcr_flag;
		next_pcr_sr = pcr_sr;
		next_pcr_ld = 1'b0;
		next_cur_str = cur_str;
		next_cur_hit = cur_hit;
		next_zhist = zhist;
		next_hist = hist;
		next_out_data = out_data;
		next_out_valid = 1'b0;
		next_out_stream = out_stream;
		next_out_start = 1'b0;
		next_out_stc = out_stc_base;
		next_lock = sync_lock;
		emit = 1'b0;
		if (in_valid)
		begin
			next_pkt_cnt = pkt_cnt + 8'h01;
			next_zhist = {zhist[7:0], in_data};
			case (st)
			pdt_pkg::S_HUNT:
			begin
				if (ps_mode)
					next_st = pdt_pkg::S_PSSCAN;
				else if (in_data == pdt_pkg::TS_SYNC)  // see R1
				begin
					next_st = pdt_pkg::S_TSH1;
					next_lock = 1'b1;
					next_pkt_cnt = 8'h01;
				end
				else
					next_lock = 1'b0;
			end
			pdt_pkg::S_TSH1:
			begin
				next_pusi = in_data[pdt_pkg::PUSI_BIT];
				next_pid = {in_data[4:0], 8'h00};
				next_st = pdt_pkg::S_TSH2;
			end
			pdt_pkg::S_TSH2:
			begin
				next_pid = {pid[12:8], in_data};
				next_cur_hit = pid_hit;
				next_cur_str = pid_str;
				next_st = pdt_pkg::S_TSH3;
			end
			pdt_pkg::S_TSH3:
			begin
				// A payload that does not open a packet continues the
				// open one, so long packets span many transport packets.
				next_pes_idx = pusi ? 4'h0 : pdt_pkg::PES_BODY;  // see R14
				next_hskip = 8'h00;
				next_pay_on = in_data[pdt_pkg::AFC_LSB] && cur_hit;
				if (in_data[pdt_pkg::AFC_LSB + 1])
					next_st = pdt_pkg::S_AFLEN;
				else if (next_pay_on)
					next_st = pdt_pkg::S_TSPAY;
				else
					next_st = pdt_pkg::S_TSSKIP;
			end
			pdt_pkg::S_AFLEN:
			begin
				next_cnt = {8'h00, in_data};
				next_af_idx = 4'h0;
				next_pcr_flag = 1'b0;
				if (in_data != 8'h00)
					next_st = pdt_pkg::S_AF;
				else if (pay_on)
					next_st = pdt_pkg::S_TSPAY;
				else
					next_st = pdt_pkg::S_TSSKIP;
			end
			pdt_pkg::S_AF:
			begin
				if (af_idx == 4'h0)
					next_pcr_flag = in_data[pdt_pkg::AF_PCR_BIT];
				else if (af_idx <= pdt_pkg::PCR_LAST_IDX)
					next_pcr_sr = {pcr_sr[39:0], in_data};
				if (af_idx == pdt_pkg::PCR_LAST_IDX && pcr_flag)
					next_pcr_ld = 1'b1;  // see R8
				if (af_idx != pdt_pkg::AF_IDX_MAX)
					next_af_idx = af_idx + 4'h1;
				next_cnt = cnt - 16'h0001;
				if (cnt == 16'h0001 && pay_on)
					next_st = pdt_pkg::S_TSPAY;
				else if (cnt == 16'h0001)
					next_st = pdt_pkg::S_TSSKIP;
			end
			pdt_pkg::S_TSPAY:
			begin
				// Header fields are skipped; the start code is taken
				// to be at the first payload byte and is not checked.
				if (pes_idx < pdt_pkg::PES_BODY)
				begin
					if (pes_idx == pdt_pkg::PES_HLEN_IDX)
						next_hskip = in_data;  // see R14
					next_pes_idx = pes_idx + 4'h1;
				end
				else if (hskip != 8'h00)
					next_hskip = hskip - 8'h01;
				else
					emit = 1'b1;
			end
			pdt_pkg::S_TSSKIP:
				next_st = pdt_pkg::S_TSSKIP;
			pdt_pkg::S_PSSCAN:
				if ({zhist, in_data} == pdt_pkg::START_PFX)
					next_st = pdt_pkg::S_PSSID;
			pdt_pkg::S_PSSID:
			begin
				next_cur_hit = sid_hit;
				next_cur_str = sid_str;
				next_pusi = (in_data == pdt_pkg::SID_PAD)
					|| (in_data == pdt_pkg::SID_PRIV2);
				if (in_data == pdt_pkg::SID_PACK
					|| in_data < pdt_pkg::SID_MIN)
					next_st = pdt_pkg::S_PSSCAN;
				else
					next_st = pdt_pkg::S_PSLEN1;
			end
			pdt_pkg::S_PSLEN1:
			begin
				next_cnt = {in_data, 8'h00};
				next_st = pdt_pkg::S_PSLEN2;
			end
			pdt_pkg::S_PSLEN2:
			begin
				next_cnt = {cnt[15:8], in_data};
				next_pes_idx = 4'h0;
				if ({cnt[15:8], in_data} == 16'h0000)
					next_st = pdt_pkg::S_PSSCAN;
				else if (!cur_hit || pusi)
					next_st = pdt_pkg::S_PSPAY;
				else
					next_st = pdt_pkg::S_PSFLG;
			end
			pdt_pkg::S_PSFLG, pdt_pkg::S_PSHLEN, pdt_pkg::S_PSHSKIP:
			begin
				next_cnt = cnt - 16'h0001;
				if (st == pdt_pkg::S_PSFLG)
				begin
					// Two flag bytes come before the header length, so the
					// length is not mistaken for the second flag byte.
					next_pes_idx = pes_idx + 4'h1;
					if (pes_idx != 4'h0)
						next_st = pdt_pkg::S_PSHLEN;
				end
				else if (st == pdt_pkg::S_PSHLEN)
				begin
					next_hskip = in_data;
					if (in_data == 8'h00)
						next_st = pdt_pkg::S_PSPAY;
					else
						next_st = pdt_pkg::S_PSHSKIP;
				end
				else
				begin
					next_hskip = hskip - 8'h01;
					if (hskip == 8'h01)
						next_st = pdt_pkg::S_PSPAY;
				end
				if (cnt == 16'h0001)
					next_st = pdt_pkg::S_PSSCAN;
			end
			pdt_pkg::S_PSPAY:
			begin
				emit = cur_hit;  // see R2
				next_cnt = cnt - 16'h0001;
				if (cnt == 16'h0001)
					next_st = pdt_pkg::S_PSSCAN;
			end
			default:
				next_st = pdt_pkg::S_HUNT;
			endcase
			if (!ps_mode && st != pdt_pkg::S_HUNT
				&& pkt_cnt == pdt_pkg::TS_LAST)
				next_st = pdt_pkg::S_HUNT;  // see R1
			if (emit)
			begin
				// Whole bytes go out in arrival order; the last two bytes
				// of each stream survive headers so split codes rejoin.
				next_out_valid = 1'b1;
				next_out_data = in_data;  // see R5, R10
				next_out_stream = cur_str;
				next_out_start = hist[cur_str] == pdt_pkg::ZERO_PAIR
					&& in_data == pdt_pkg::SC_LAST;  // see R9
				next_hist[cur_str] = {hist[cur_str][7:0], in_data};
				next_out_stc = stc_base[cur_tb*pdt_pkg::BASE_W +:
					pdt_pkg::BASE_W];  // see R13
			end
		end
		if (st != pdt_pkg::S_HUNT && ps_mode != st[3])
		begin
			next_st = pdt_pkg::S_HUNT;
			next_lock = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= pdt_pkg::S_HUNT;
			pkt_cnt <= 8'h00;
			pid <= '0;
			pusi <= 1'b0;
			pay_on <= 1'b0;
			cnt <= 16'h0000;
			hskip <= 8'h00;
			pes_idx <= 4'h0;
			af_idx <= 4'h0;
			pcr_flag <= 1'b0;
			pcr_sr <= 48'h000000000000;
			pcr_ld <= 1'b0;
			cur_str <= '0;
			cur_hit <= 1'b0;
			zhist <= 16'hffff;
			for (int i = 0; i < pdt_pkg::NSTR; i++)
				hist[i] <= 16'hffff;
			out_data <= 8'h00;
			out_valid <= 1'b0;
			out_stream <= '0;
			out_start <= 1'b0;
			out_stc_base <= '0;
			sync_lock <= 1'b0;
		end
		else if (ce)
		begin
			st <= next_st;
			pkt_cnt <= next_pkt_cnt;
			pid <= next_pid;
			pusi <= next_pusi;
			pay_on <= next_pay_on;
			cnt <= next_cnt;
			hskip <= next_hskip;
			pes_idx <= next_pes_idx;
			af_idx <= next_af_idx;
			pcr_flag <= next_pcr_flag;
			pcr_sr <= next_pcr_sr;
			pcr_ld <= next_pcr_ld;
			cur_str <= next_cur_str;
			cur_hit <= next_cur_hit;
			zhist <= next_zhist;
			hist <= next_hist;
			out_data <= next_out_data;
			out_valid <= next_out_valid;
			out_stream <= next_out_stream;
			out_start <= next_out_start;
			out_stc_base <= next_out_stc;
			sync_lock <= next_lock;
		end
	end

	// ***********************************************************
	// Checks
	// ***********************************************************
	sync_found_a: assert property (@(posedge clk) disable iff (srst) // see R1
		(ce && in_valid && !ps_mode && st == pdt_pkg::S_HUNT
		&& in_data == pdt_pkg::TS_SYNC) |=> (st == pdt_pkg::S_TSH1 && sync_lock))
		else $error("Sync byte not taken.");

	pkt_end_a: assert property (@(posedge clk) disable iff (srst) // see R1
		(ce && in_valid && !ps_mode && st != pdt_pkg::S_HUNT
		&& pkt_cnt == pdt_pkg::TS_LAST) |=> st == pdt_pkg::S_HUNT)
		else $error("Packet did not end after 188 bytes.");

	one_stream_a: assert property (@(posedge clk) disable iff (srst) // see R2
		(ce && in_valid && st == pdt_pkg::S_PSPAY && cur_hit)
		|=> (out_valid && out_stream == $past(cur_str)))
		else $error("Payload byte not sent to its stream.");

	select_hit_a: assert property (@(posedge clk) disable iff (srst) // see R3
		(ce && out_valid) |-> $past(cur_hit))
		else $error("Byte sent for an unselected packet.");

	byte_order_a: assert property (@(posedge clk) disable iff (srst) // see R5
		(ce && out_valid) |-> out_data == $past(in_data))
		else $error("Output byte differs from input byte.");

	code_join_a: assert property (@(posedge clk) disable iff (srst) // see R9
		(ce && out_start) |-> (out_data == pdt_pkg::SC_LAST && out_valid))
		else $error("Start code flag on wrong byte.");

	pcr_take_a: assert property (@(posedge clk) disable iff (srst) // see R8
		(ce && pcr_ld) |-> ($past(pcr_flag)
		&& $past(af_idx) == pdt_pkg::PCR_LAST_IDX))
		else $error("Clock reference loaded without its field.");

	hdr_len_a: assert property (@(posedge clk) disable iff (srst) // see R14
		(ce && in_valid && st == pdt_pkg::S_TSPAY
		&& pes_idx == pdt_pkg::PES_HLEN_IDX) |=> hskip == $past(in_data))
		else $error("Header length not captured.");

endmodule
`default_nettype wire

// ===== tb/pdt_src.sv
`timescale 1ns/1ps
`default_nettype none
module pdt_src
(
	input  wire logic       clk,
	output logic      [7:0] in_data,
	output logic            in_valid
);
	// Each idle cycle inside a send inverts the byte left on the bus, so a stale byte sampled by mistake after one idle cycle
	// differs from the last byte sent; a second idle cycle inverts it back to that byte.
	initial
	begin
		in_data = 8'h00;
		in_valid = 1'b0;
	end

	// Slow mode inserts zero to two idle cycles before each byte.
	task automatic send(input logic [7:0] q[$], input bit slow);
		for (int i = 0; i < q.size(); i++)
		begin
			repeat (slow ? i % 3 : 0)
			begin
				@(posedge clk);
				in_valid <= 1'b0;
				in_data <= ~in_data;
			end
			@(posedge clk);
			in_valid <= 1'b1;
			in_data <= q[i];
		end
		@(posedge clk);
		in_valid <= 1'b0;
		in_data <= ~in_data;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                                    clk = 1'b0;
	logic                                    srst = 1'b1;
	logic                                    ps_mode = 1'b0;
	logic                                    ce = 1'b1;
	wire  logic [7:0]                        in_data;
	wire  logic                              in_valid;
	logic [3:0]                              str_en = 4'h0;
	logic [51:0]                             str_pid = '0;
	logic [31:0]                             str_sid = '0;
	logic [3:0]                              str_tb = '0;
	logic [25:0]                             pcr_pid = '0;
	logic [7:0]                              out_data;
	logic                                    out_valid;
	logic [1:0]                              out_stream;
	logic                                    out_start;
	logic [32:0]                             out_stc_base;
	logic                                    sync_lock;
	logic [65:0]                             stc_base;
	logic [17:0]                             stc_ext;
	logic [65:0]                             tb_err;
	int                                      n_fail = 0;
	int                                      total_checks = 0;
	logic [31:0]                             rs = 32'd21;
	logic [15:0]                             hist [4] = '{default: 16'hffff};
	logic [10:0]                             exp_q[$];
	logic [10:0]                             got_q[$];
	logic [7:0]                              pay[$];
	logic [7:0]                              q[$];
	logic [7:0]                              b;
	logic [32:0]                             pcr_b = 33'h1_2345_6789;
	logic [8:0]                              pcr_e = 9'h010;
	logic [63:0]                             t0;
	logic [63:0]                             t1;

	always #10 clk = ~clk;

	pdt_src pdt_src_inst (.clk(clk), .in_data(in_data), .in_valid(in_valid));

	pdt_demux pdt_demux_inst
	(
		.clk(clk), .srst(srst), .ce(ce), .ps_mode(ps_mode),
		.in_data(in_data), .in_valid(in_valid), .str_en(str_en),
		.str_pid(str_pid), .str_sid(str_sid), .str_tb(str_tb),
		.pcr_pid(pcr_pid), .out_data(out_data), .out_valid(out_valid),
		.out_stream(out_stream), .out_start(out_start),
		.out_stc_base(out_stc_base), .sync_lock(sync_lock),
		.stc_base(stc_base), .stc_ext(stc_ext), .tb_err(tb_err)
	);

	always @(posedge clk)
		if (out_valid === 1'b1)
			got_q.push_back({out_start, out_stream, out_data});

	// ***********************************************************
	// Helpers
	// ***********************************************************
	function automatic logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction

	// A start code counts only over bytes emitted on the same stream.
	function automatic void expect_b(input logic [1:0] s, input logic [7:0] v);
		exp_q.push_back({hist[s] == 16'h0000 && v == 8'h01, s, v});
		hist[s] = {hist[s][7:0], v};
	endfunction

	task automatic check(input logic c, input string m);
		total_checks++;
		if (c !== 1'b1)
		begin
			n_fail++;
			$display("Error %0t %s", $time, m);
		end
	endtask

	task automatic fill();
		pay = {};
		repeat (184) pay.push_back(rnd());
	endtask

	// One 188-byte packet; stream s < 0 means nothing is expected.
	task automatic ts(input logic [12:0] pid, input logic [7:0] b3,
		input int s, input int skip, input bit slow);
		logic [7:0] pk[$];
		pk = {8'h47, 8'({1'b0, skip > 0, 1'b0, pid[12:8]}), pid[7:0], b3,
			pay};
		if (s >= 0)
			for (int i = skip; i < 184; i++)
				expect_b(s[1:0], pay[i]);
		pdt_src_inst.send(pk, slow);
	endtask

	task automatic drain();
		repeat (4) @(posedge clk);
		check(got_q == exp_q, "payload bytes differ");
		got_q = {};
		exp_q = {};
	endtask

	task automatic close_out();
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		n_fail++;
		$display("Error %0t run did not finish", $time);
		close_out();
	end

	// ***********************************************************
	// Scenarios
	// ***********************************************************
	initial
	begin
		repeat (10) @(posedge clk);
		check(sync_lock === 1'b0 && out_valid === 1'b0, "reset state");
		srst <= 1'b0;
		str_en <= 4'h7;
		str_pid <= {13'h0, 13'h0, 13'h1ff, 13'h100};
		str_sid <= {8'h00, 8'hc0, 8'h00, 8'h00};
		str_tb <= 4'b0010;
		pcr_pid <= {13'h0bb, 13'h0aa};
		@(posedge clk);
		fill();
		pay = {8'h00, 8'h00, 8'h01, 8'he0, 8'h00, 8'h00, 8'h80, 8'h00, 8'h02,
			pay[9:$]};
		pay[182] = 8'h00;
		pay[183] = 8'h00;
		ts(13'h100, 8'h10, 0, 11, 0);
		check(sync_lock === 1'b1, "no lock after sync byte");
		fill();
		ts(13'h1ff, 8'h11, 1, 0, 1);
		fill();
		ts(13'h055, 8'h12, -1, 0, 0);
		fill();
		pay[0] = 8'h01;
		ts(13'h100, 8'h11, 0, 0, 1);
		drain();
		fill();
		foreach (pay[i])
			if (pay[i] == 8'h47)
				pay[i] = 8'h46;
		pdt_src_inst.send({8'h00, 8'h01, 8'h00, 8'h10, pay}, 0);
		check(sync_lock === 1'b0, "lock kept without sync byte");
		drain();
		pay = {8'd183, 8'h10, pcr_b[32:25], pcr_b[24:17], pcr_b[16:9],
			pcr_b[8:1], 8'({pcr_b[0], 6'h3f, pcr_e[8]}), pcr_e[7:0]};
		repeat (176) pay.push_back(8'hff);
		ts(13'h0aa, 8'h20, -1, 0, 0);
		repeat (4) @(posedge clk);
		check(stc_base[32:0] === pcr_b, "base not loaded");
		check(stc_ext[8:0] < 9'd300, "extension out of range");
		check(stc_base[65:33] < 33'd100, "second base disturbed");
		check(pcr_b - tb_err[32:0] < 33'd100, "phase error wrong");
		t0 = 64'(stc_base[32:0]) * 64'd300 + 64'(stc_ext[8:0]);
		repeat (5000) @(posedge clk);
		t1 = 64'(stc_base[32:0]) * 64'd300 + 64'(stc_ext[8:0]);
		check(t1 - t0 >= 64'd2698 && t1 - t0 <= 64'd2702, "rate");
		ce <= 1'b0;
		repeat (2) @(posedge clk);
		t0 = 64'(stc_base[32:0]) * 64'd300 + 64'(stc_ext[8:0]);
		repeat (20) @(posedge clk);
		t1 = 64'(stc_base[32:0]) * 64'd300 + 64'(stc_ext[8:0]);
		check(t1 == t0, "time base ran while disabled");
		ce <= 1'b1;
		fill();
		ts(13'h100, 8'h13, 0, 0, 0);
		repeat (2) @(posedge clk);
		check(out_stc_base - pcr_b < 33'd20, "stream 0 base");
		fill();
		ts(13'h1ff, 8'h12, 1, 0, 1);
		repeat (2) @(posedge clk);
		check(out_stc_base < 33'd100, "stream 1 base");
		drain();
		ps_mode <= 1'b1;
		@(posedge clk);
		q = {8'h00, 8'h00, 8'h01, 8'hc1, 8'h00, 8'h05, 8'h80, 8'h00, 8'h00,
			8'h11, 8'h22, 8'h00, 8'h00, 8'h01, 8'hc0, 8'h00, 8'h11, 8'h80};
		// The selected packet carries a clock reference and a rate field
		// in its header, and neither may reach the output.
		q = {q, 8'h30, 8'h09, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01,
			8'h80, 8'h00, 8'h03};
		repeat (5)
		begin
			b = rnd();
			q.push_back(b);
			expect_b(2'd2, b);
		end
		pdt_src_inst.send(q, 1);
		drain();
		close_out();
	end
endmodule
`default_nettype wire
